// ---- src/soc_interrupt_controller.sv ----
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RULE_01: all 54 sources can raise requests
// RULE_02: each source steered to normal or fast
// RULE_03: thirty-two priority slots for normal vectoring
// RULE_04: two priority levels for fast vectoring
// RULE_05: internal sources level, polarity per source
// RULE_06: pin trigger: high, low, rise, fall, both
// RULE_07: dedicated lines always level, active high
// RULE_08: all nineteen port pins can interrupt
// RULE_09: each pin output, input or interrupt
// RULE_10: software priority mask over normal and fast
// RULE_11: edges stay pending, levels follow source
module soc_interrupt_controller (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [31:0] periph_irq,
    input  wire logic [2:0]  ext_irq_pin,
    input  wire logic [15:0] expanded_port_pins_in,
    output logic      [15:0] expanded_port_pins_out,
    output logic      [15:0] expanded_port_pins_oe,
    input  wire logic [2:0]  secondary_port_pins_in,
    output logic      [2:0]  secondary_port_pins_out,
    output logic      [2:0]  secondary_port_pins_oe,
    output logic             normal_interrupt_request,
    output logic             fast_interrupt_request
);
    typedef struct packed {
        logic [53:0]      enable;
        logic [53:0]      select;
        logic [31:0]      polarity;
        logic [18:0]      pin_dir;
        logic [18:0]      pin_int;
        logic [18:0]      pin_data;
        logic [18:0][2:0] pin_trig;
        logic [5:0]       irq_mask;
        logic [1:0]       fast_mask;
        logic [31:0][5:0] irq_slot;
        logic [1:0][5:0]  fast_slot;
        logic [18:0]      edge_pend;
        logic             irq;
        logic             fast;
        logic [4:0]       irq_vec;
        logic             irq_vld;
        logic             fast_lvl;
        logic             fast_vld;
        logic [31:0]      rdata;
    } ctrl_state_s;

    ctrl_state_s st;
    ctrl_state_s next_st;

    logic [21:0] line_in;
    logic [21:0] line_level;
    logic [21:0] line_edge;
    logic [21:0] line_state;
    logic [53:0] status;
    logic [63:0] live;
    logic [31:0] slot_hit;
    logic [1:0]  fast_hit;
    logic [18:0] clr_pin;

    assign line_in = {secondary_port_pins_in, expanded_port_pins_in,
                      ext_irq_pin};

    // RULE_05 per-source polarity
    assign status[intc_pkg::NUM_INT-1:0] = periph_irq ^ st.polarity;

    genvar j;
    generate
        for (j = 0; j < intc_pkg::NUM_EXT + intc_pkg::NUM_PIN; j++)
        begin : g_line
            logic [2:0] trig_sel;
            if (j < intc_pkg::NUM_EXT) begin : g_ext
                // RULE_07 fixed high level
                assign trig_sel = intc_pkg::TRIG_HIGH;
                assign status[intc_pkg::EXT_BASE + j] = line_level[j];
            end else begin : g_pin
                localparam int P = j - intc_pkg::NUM_EXT;
                logic pin_edge_type;
                assign trig_sel = st.pin_trig[P];
                assign pin_edge_type = (st.pin_trig[P] != intc_pkg::TRIG_HIGH)
                    && (st.pin_trig[P] != intc_pkg::TRIG_LOW);
                // RULE_08 RULE_09 only interrupt-mode inputs raise
                assign status[intc_pkg::PIN_BASE + P] =
                    st.pin_int[P] & ~st.pin_dir[P] &
                    (pin_edge_type ? st.edge_pend[P] : line_level[j]);
            end
            pin_trigger u_trig (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .pin_raw   (line_in[j]),
                .trig      (trig_sel),
                .level_hit (line_level[j]),
                .edge_hit  (line_edge[j]),
                .pin_level (line_state[j])
            );
        end
    endgenerate

    // RULE_01 every source reaches the request logic
    assign live = {10'h000, status & st.enable};

    genvar k;
    generate
        for (k = 0; k < intc_pkg::IRQ_SLOTS; k++) begin : g_slot
            // RULE_03 RULE_10 slot below mask level
            assign slot_hit[k] = live[st.irq_slot[k]] &
                ~st.select[st.irq_slot[k] % 54] & (6'(k) < st.irq_mask) &
                (st.irq_slot[k] < 6'(intc_pkg::NUM_SRC));
        end
        for (k = 0; k < intc_pkg::FAST_SLOTS; k++) begin : g_fslot
            // RULE_04 RULE_10 two fast levels under mask
            assign fast_hit[k] = live[st.fast_slot[k]] &
                st.select[st.fast_slot[k] % 54] &
                (2'(k) < st.fast_mask) &
                (st.fast_slot[k] < 6'(intc_pkg::NUM_SRC));
        end
    endgenerate

    assign clr_pin = (reg_wr && reg_addr == intc_pkg::ADDR_CLEAR_HI) ?
        reg_wdata[intc_pkg::HI_PIN_LSB +: intc_pkg::NUM_PIN] : 19'h00000;

    always_comb begin
        logic [5:0] slot_idx;
        logic       any_norm;
        logic       any_fast;
        slot_idx = reg_addr[7:2] - intc_pkg::ADDR_SLOT_BASE[7:2];
        any_norm = |(live[53:0] & ~st.select);
        any_fast = |(live[53:0] & st.select);
        next_st = st;
        next_st.rdata = 32'h00000000;

        // RULE_11 edge pending held, set beats clear
        next_st.edge_pend = (st.edge_pend & ~clr_pin) |
            (line_edge[21:3] & st.pin_int & ~st.pin_dir);

        if (reg_wr) begin
            unique case (reg_addr)
                intc_pkg::ADDR_ENABLE_LO: next_st.enable[31:0] = reg_wdata;
                intc_pkg::ADDR_ENABLE_HI:
                    next_st.enable[53:32] = reg_wdata[21:0];
                // RULE_02 steering select, 1 means fast
                intc_pkg::ADDR_SELECT_LO: next_st.select[31:0] = reg_wdata;
                intc_pkg::ADDR_SELECT_HI:
                    next_st.select[53:32] = reg_wdata[21:0];
                intc_pkg::ADDR_POLARITY:  next_st.polarity = reg_wdata;
                // RULE_09 pin mode registers
                intc_pkg::ADDR_PIN_DIR:   next_st.pin_dir = reg_wdata[18:0];
                intc_pkg::ADDR_PIN_INT:   next_st.pin_int = reg_wdata[18:0];
                intc_pkg::ADDR_PIN_DATA:  next_st.pin_data = reg_wdata[18:0];
                intc_pkg::ADDR_TRIG_LO:
                    next_st.pin_trig[9:0] = reg_wdata[29:0];
                intc_pkg::ADDR_TRIG_HI:
                    next_st.pin_trig[18:10] = reg_wdata[26:0];
                // RULE_10 mask levels
                intc_pkg::ADDR_PRIO_MASK: begin
                    next_st.irq_mask = reg_wdata[5:0];
                    next_st.fast_mask =
                        reg_wdata[intc_pkg::FAST_MASK_LSB +: 2];
                end
                intc_pkg::ADDR_FAST_SLOT0:
                    next_st.fast_slot[0] = reg_wdata[5:0];
                intc_pkg::ADDR_FAST_SLOT1:
                    next_st.fast_slot[1] = reg_wdata[5:0];
                default: begin
                    if (reg_addr >= intc_pkg::ADDR_SLOT_BASE) begin
                        next_st.irq_slot[slot_idx[4:0]] = reg_wdata[5:0];
                    end
                end
            endcase
        end

        // RULE_03 lowest slot number wins
        next_st.irq_vld = |slot_hit;
        next_st.irq_vec = 5'h00;
        for (int s = intc_pkg::IRQ_SLOTS - 1; s >= 0; s--) begin
            if (slot_hit[s]) begin
                next_st.irq_vec = 5'(s);
            end
        end
        // RULE_04 level 0 before level 1
        next_st.fast_vld = |fast_hit;
        next_st.fast_lvl = ~fast_hit[0] & fast_hit[1];
        // unslotted sources only pass a fully open mask
        next_st.irq = (|slot_hit) ||
            (st.irq_mask == 6'(intc_pkg::IRQ_SLOTS) && any_norm);
        next_st.fast = (|fast_hit) ||
            (st.fast_mask == 2'(intc_pkg::FAST_SLOTS) && any_fast);

        if (reg_rd) begin
            unique case (reg_addr)
                intc_pkg::ADDR_STATUS_LO: next_st.rdata = status[31:0];
                intc_pkg::ADDR_STATUS_HI:
                    next_st.rdata = {10'h000, status[53:32]};
                intc_pkg::ADDR_ENABLE_LO: next_st.rdata = st.enable[31:0];
                intc_pkg::ADDR_ENABLE_HI:
                    next_st.rdata = {10'h000, st.enable[53:32]};
                intc_pkg::ADDR_SELECT_LO: next_st.rdata = st.select[31:0];
                intc_pkg::ADDR_SELECT_HI:
                    next_st.rdata = {10'h000, st.select[53:32]};
                intc_pkg::ADDR_POLARITY:  next_st.rdata = st.polarity;
                intc_pkg::ADDR_PIN_DIR:
                    next_st.rdata = {13'h0000, st.pin_dir};
                intc_pkg::ADDR_PIN_INT:
                    next_st.rdata = {13'h0000, st.pin_int};
                intc_pkg::ADDR_PIN_DATA:
                    next_st.rdata = {13'h0000, st.pin_data};
                intc_pkg::ADDR_PIN_LEVEL:
                    next_st.rdata = {13'h0000, line_state[21:3]};
                intc_pkg::ADDR_TRIG_LO:
                    next_st.rdata = {2'h0, st.pin_trig[9:0]};
                intc_pkg::ADDR_TRIG_HI:
                    next_st.rdata = {5'h00, st.pin_trig[18:10]};
                intc_pkg::ADDR_PRIO_MASK:
                    next_st.rdata = {22'h000000, st.fast_mask, 2'h0,
                                     st.irq_mask};
                intc_pkg::ADDR_VECTOR:
                    next_st.rdata = {22'h000000, st.fast_vld, st.fast_lvl,
                                     st.irq_vld, 2'h0, st.irq_vec};
                intc_pkg::ADDR_FAST_SLOT0:
                    next_st.rdata = {26'h0000000, st.fast_slot[0]};
                intc_pkg::ADDR_FAST_SLOT1:
                    next_st.rdata = {26'h0000000, st.fast_slot[1]};
                default: begin
                    if (reg_addr >= intc_pkg::ADDR_SLOT_BASE) begin
                        next_st.rdata = {26'h0000000,
                                         st.irq_slot[slot_idx[4:0]]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.irq_mask <= intc_pkg::RST_IRQ_MASK;
            st.fast_mask <= intc_pkg::RST_FAST_MASK;
            st.irq_slot  <= {32{intc_pkg::RST_SLOT}};
            st.fast_slot <= {2{intc_pkg::RST_SLOT}};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata                = st.rdata;
    assign normal_interrupt_request = st.irq;
    assign fast_interrupt_request   = st.fast;
    assign expanded_port_pins_out   = st.pin_data[15:0];
    assign expanded_port_pins_oe    = st.pin_dir[15:0];
    assign secondary_port_pins_out  = st.pin_data[18:16];
    assign secondary_port_pins_oe   = st.pin_dir[18:16];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_slot_hit_irq: assert property ( // RULE_03
        (|slot_hit) |=> normal_interrupt_request)
        else $error("slot hit without normal request");

    a_vector_top: assert property ( // RULE_03
        slot_hit[0] |=> (st.irq_vld && st.irq_vec == 5'h00))
        else $error("slot 0 did not win the vector");

    a_fast_top: assert property ( // RULE_04
        fast_hit[0] |=> (fast_interrupt_request && !st.fast_lvl))
        else $error("fast level 0 not reported");

    a_steer_normal: assert property ( // RULE_02
        !(|(live[53:0] & ~st.select)) |=> !normal_interrupt_request)
        else $error("normal request with no normal source");

    a_steer_fast: assert property ( // RULE_02
        !(|(live[53:0] & st.select)) |=> !fast_interrupt_request)
        else $error("fast request with no fast source");

    a_mask_zero: assert property ( // RULE_10
        (st.irq_mask == 6'h00) |=> !normal_interrupt_request)
        else $error("normal request passed a closed mask");

    a_pin_dir: assert property ( // RULE_09
        (reg_wr && reg_addr == intc_pkg::ADDR_PIN_DIR) |=>
        (expanded_port_pins_oe == $past(reg_wdata[15:0])))
        else $error("pin direction write not applied");

    a_sec_dir: assert property ( // RULE_09
        (reg_wr && reg_addr == intc_pkg::ADDR_PIN_DIR) |=>
        (secondary_port_pins_oe == $past(reg_wdata[18:16])))
        else $error("secondary direction write not applied");

    a_edge_sticky: assert property ( // RULE_11
        (st.edge_pend[0] && !clr_pin[0]) |=> st.edge_pend[0])
        else $error("edge pending lost without a clear");

    a_edge_clear: assert property ( // RULE_11
        (clr_pin[0] && !line_edge[3]) |=> !st.edge_pend[0])
        else $error("edge pending kept after a clear");

    a_int_level: assert property ( // RULE_05
        (st.enable[0] && !st.select[0] && st.irq_mask == 6'h20 &&
         periph_irq[0] != st.polarity[0]) |=> normal_interrupt_request)
        else $error("active internal source not requested");

    a_ext_level: assert property ( // RULE_07
        (st.enable[32] && !st.select[32] && st.irq_mask == 6'h20 &&
         line_level[0]) |=> normal_interrupt_request)
        else $error("active dedicated line not requested");
endmodule // soc_interrupt_controller
`default_nettype wire

// ---- src/intc_pkg.sv ----
package intc_pkg;
    // source numbering: internal, then dedicated lines, then port pins
    localparam int NUM_SRC   = 54;
    localparam int NUM_INT   = 32;
    localparam int NUM_EXT   = 3;
    localparam int NUM_EXP   = 16;
    localparam int NUM_SEC   = 3;
    localparam int NUM_PIN   = 19;
    localparam int EXT_BASE  = 32;
    localparam int PIN_BASE  = 35;
    localparam int IRQ_SLOTS = 32;
    localparam int FAST_SLOTS = 2;
    localparam int SRC_W     = 6;
    localparam int TRIG_W    = 3;
    // pin fields inside the high words start at this bit
    localparam int HI_PIN_LSB = 3;
    localparam int TRIG_LO_PINS = 10;

    localparam logic [7:0] ADDR_STATUS_LO  = 8'h00;
    localparam logic [7:0] ADDR_STATUS_HI  = 8'h04;
    localparam logic [7:0] ADDR_ENABLE_LO  = 8'h08;
    localparam logic [7:0] ADDR_ENABLE_HI  = 8'h0C;
    localparam logic [7:0] ADDR_CLEAR_LO   = 8'h10;
    localparam logic [7:0] ADDR_CLEAR_HI   = 8'h14;
    localparam logic [7:0] ADDR_SELECT_LO  = 8'h18;
    localparam logic [7:0] ADDR_SELECT_HI  = 8'h1C;
    localparam logic [7:0] ADDR_POLARITY   = 8'h20;
    localparam logic [7:0] ADDR_PIN_DIR    = 8'h24;
    localparam logic [7:0] ADDR_PIN_INT    = 8'h28;
    localparam logic [7:0] ADDR_PIN_DATA   = 8'h2C;
    localparam logic [7:0] ADDR_PIN_LEVEL  = 8'h30;
    localparam logic [7:0] ADDR_TRIG_LO    = 8'h34;
    localparam logic [7:0] ADDR_TRIG_HI    = 8'h38;
    localparam logic [7:0] ADDR_PRIO_MASK  = 8'h3C;
    localparam logic [7:0] ADDR_VECTOR     = 8'h40;
    localparam logic [7:0] ADDR_FAST_SLOT0 = 8'h44;
    localparam logic [7:0] ADDR_FAST_SLOT1 = 8'h48;
    localparam logic [7:0] ADDR_SLOT_BASE  = 8'h80;
    localparam logic [7:0] ADDR_SLOT_LAST  = 8'hFC;

    localparam int FAST_MASK_LSB = 8;
    localparam int VEC_VALID_BIT = 7;
    localparam int FAST_LVL_BIT  = 8;
    localparam int FAST_VLD_BIT  = 9;

    localparam logic [2:0] TRIG_HIGH = 3'h0;
    localparam logic [2:0] TRIG_LOW  = 3'h1;
    localparam logic [2:0] TRIG_RISE = 3'h2;
    localparam logic [2:0] TRIG_FALL = 3'h3;
    localparam logic [2:0] TRIG_BOTH = 3'h4;

    localparam logic [5:0] RST_IRQ_MASK = 6'h20;
    localparam logic [1:0] RST_FAST_MASK = 2'h2;
    localparam logic [5:0] RST_SLOT     = 6'h3F;
endpackage

// ---- src/pin_trigger.sv ----
`timescale 1ns/10ps
`default_nettype none
module pin_trigger (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       pin_raw,
    input  wire logic [2:0] trig,
    output logic            level_hit,
    output logic            edge_hit,
    output logic            pin_level
);
    typedef struct packed {
        logic [2:0] sync;
        logic       state;
        logic       edge_seen;
    } trig_state_s;

    trig_state_s st;
    trig_state_s next_st;

    localparam logic [2:0] TRIG_RISE_C = intc_pkg::TRIG_RISE;
    localparam logic [2:0] TRIG_FALL_C = intc_pkg::TRIG_FALL;
    localparam logic [2:0] TRIG_BOTH_C = intc_pkg::TRIG_BOTH;

    always_comb begin
        next_st = st;
        // sync[0] feeds sync[1] only
        next_st.sync = {st.sync[1:0], pin_raw};
        if (st.sync[1] == st.sync[2]) begin
            next_st.state = st.sync[2];
        end
        // RULE_06 edge trigger types
        unique case (trig)
            TRIG_RISE_C: next_st.edge_seen = next_st.state & ~st.state;
            TRIG_FALL_C: next_st.edge_seen = ~next_st.state & st.state;
            TRIG_BOTH_C: next_st.edge_seen = next_st.state ^ st.state;
            default:     next_st.edge_seen = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // RULE_06 level trigger types
    assign level_hit = (trig == intc_pkg::TRIG_HIGH) ? st.state :
                       (trig == intc_pkg::TRIG_LOW) ? ~st.state : 1'b0;
    assign edge_hit  = st.edge_seen;
    assign pin_level = st.state;
endmodule // pin_trigger
`default_nettype wire

// ---- tb/core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       normal_interrupt_request,
    input  wire logic       fast_interrupt_request,
    output logic      [7:0] irq_entries,
    output logic      [7:0] fast_entries
);
    logic irq_q;
    logic fast_q;
    // one entry per rise: a held level is a single handler call
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_q       <= 1'b0;
            fast_q       <= 1'b0;
            irq_entries  <= 8'h00;
            fast_entries <= 8'h00;
        end else begin
            irq_q  <= normal_interrupt_request;
            fast_q <= fast_interrupt_request;
            if (normal_interrupt_request && !irq_q)
                irq_entries <= irq_entries + 8'h01;
            if (fast_interrupt_request && !fast_q)
                fast_entries <= fast_entries + 8'h01;
        end
    end
endmodule // core_model
`default_nettype wire

// ---- tb/soc_interrupt_controller_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module soc_interrupt_controller_tb;
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] periph_irq = 32'h0;
    logic [2:0]  ext_irq_pin = 3'h0;
    logic [15:0] exp_in = 16'h0;
    logic [15:0] exp_out;
    logic [15:0] exp_oe;
    logic [2:0]  sec_in = 3'h0;
    logic [2:0]  sec_out;
    logic [2:0]  sec_oe;
    logic        normal_interrupt_request;
    logic        fast_interrupt_request;
    logic [7:0]  irq_entries;
    logic [7:0]  fast_entries;
    logic [31:0] d;
    logic [2:0]  trig_exp [5] = '{3'h2, 3'h5, 3'h2, 3'h1, 3'h3};
    int          error_cnt = 0;
    int          n_checks = 0;

    always #2 clk_sys = ~clk_sys;

    soc_interrupt_controller i_soc_interrupt_controller (
        .clk_sys                  (clk_sys),
        .rst_n                    (rst_n),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_rdata                (reg_rdata),
        .periph_irq               (periph_irq),
        .ext_irq_pin              (ext_irq_pin),
        .expanded_port_pins_in    (exp_in),
        .expanded_port_pins_out   (exp_out),
        .expanded_port_pins_oe    (exp_oe),
        .secondary_port_pins_in   (sec_in),
        .secondary_port_pins_out  (sec_out),
        .secondary_port_pins_oe   (sec_oe),
        .normal_interrupt_request (normal_interrupt_request),
        .fast_interrupt_request   (fast_interrupt_request)
    );

    core_model i_core_model (
        .clk_sys                  (clk_sys),
        .rst_n                    (rst_n),
        .normal_interrupt_request (normal_interrupt_request),
        .fast_interrupt_request   (fast_interrupt_request),
        .irq_entries              (irq_entries),
        .fast_entries             (fast_entries)
    );

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // bounded wait for a request level, then one compare
    task automatic wait_req(input bit fast, input logic exp);
        int   i;
        logic s;
        // step off the edge so a just-launched request is settled
        #1;
        for (i = 0; i < 20; i++) begin
            s = fast ? fast_interrupt_request : normal_interrupt_request;
            if (s === exp)
                break;
            @(posedge clk_sys);
            #1;
        end
        check({31'h0, s}, {31'h0, exp});
        if (i == 20)
            final_report();
    endtask

    task automatic settle();
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(intc_pkg::ADDR_PRIO_MASK, d); check(d, 32'h0000_0220);
        rd(intc_pkg::ADDR_SLOT_BASE, d); check(d, 32'h0000_003F);
        rd(intc_pkg::ADDR_FAST_SLOT0, d); check(d, 32'h0000_003F);
        rd(8'h4C, d); check(d, 32'h0);
        wr(intc_pkg::ADDR_STATUS_LO, 32'hFFFF_FFFF);
        rd(intc_pkg::ADDR_STATUS_LO, d); check(d, 32'h0);
        $display("test reset done");

        // two normal sources, lower slot wins, mask cuts by slot
        wr(intc_pkg::ADDR_ENABLE_LO, 32'h0000_000F);
        wr(intc_pkg::ADDR_SLOT_BASE + 8'h14, 32'h0);
        wr(intc_pkg::ADDR_SLOT_BASE + 8'h0C, 32'h1);
        @(posedge clk_sys) periph_irq <= 32'h3;
        wait_req(1'b0, 1'b1);
        rd(intc_pkg::ADDR_STATUS_LO, d); check(d, 32'h3);
        rd(intc_pkg::ADDR_VECTOR, d); check(d & 32'h9F, 32'h83);
        @(posedge clk_sys) periph_irq <= 32'h1;
        rd(intc_pkg::ADDR_VECTOR, d); check(d & 32'h9F, 32'h85);
        // software keeps the mask: slot 5 blocked at 5, open at 6
        wr(intc_pkg::ADDR_PRIO_MASK, 32'h0000_0205);
        wait_req(1'b0, 1'b0);
        wr(intc_pkg::ADDR_PRIO_MASK, 32'h0000_0206);
        wait_req(1'b0, 1'b1);
        @(posedge clk_sys) periph_irq <= 32'h0;
        wait_req(1'b0, 1'b0);
        wr(intc_pkg::ADDR_POLARITY, 32'h1);
        wait_req(1'b0, 1'b1);
        wr(intc_pkg::ADDR_PRIO_MASK, 32'h0000_0200);
        wait_req(1'b0, 1'b0);
        wr(intc_pkg::ADDR_POLARITY, 32'h0);
        wait_req(1'b0, 1'b0);
        wr(intc_pkg::ADDR_PRIO_MASK, 32'h0000_0220);
        check({24'h0, irq_entries}, 32'h3);
        $display("test normal done");

        // fast steering, two fast levels
        wr(intc_pkg::ADDR_SELECT_LO, 32'h0000_000C);
        wr(intc_pkg::ADDR_FAST_SLOT0, 32'h3);
        wr(intc_pkg::ADDR_FAST_SLOT1, 32'h2);
        @(posedge clk_sys) periph_irq <= 32'hC;
        wait_req(1'b1, 1'b1);
        check({31'h0, normal_interrupt_request}, 32'h0);
        rd(intc_pkg::ADDR_VECTOR, d); check(d & 32'h300, 32'h200);
        @(posedge clk_sys) periph_irq <= 32'h4;
        rd(intc_pkg::ADDR_VECTOR, d); check(d & 32'h300, 32'h300);
        wr(intc_pkg::ADDR_PRIO_MASK, 32'h0000_0120);
        wait_req(1'b1, 1'b0);
        wr(intc_pkg::ADDR_PRIO_MASK, 32'h0000_0220);
        wait_req(1'b1, 1'b1);
        @(posedge clk_sys) periph_irq <= 32'h0;
        wait_req(1'b1, 1'b0);
        check({24'h0, fast_entries}, 32'h2);
        $display("test fast done");

        // dedicated line 0 is source 32, active high level
        wr(intc_pkg::ADDR_ENABLE_HI, 32'h0000_0009);
        wr(intc_pkg::ADDR_SLOT_BASE, 32'h20);
        @(posedge clk_sys) ext_irq_pin <= 3'h1;
        wait_req(1'b0, 1'b1);
        rd(intc_pkg::ADDR_VECTOR, d); check(d & 32'h9F, 32'h80);
        rd(intc_pkg::ADDR_STATUS_HI, d); check(d & 32'h1, 32'h1);
        @(posedge clk_sys) ext_irq_pin <= 3'h0;
        wait_req(1'b0, 1'b0);
        $display("test dedicated done");

        // every trigger code on pin 0: level, low, rise, fall, both
        wr(intc_pkg::ADDR_PIN_INT, 32'h1);
        for (int c = 0; c < 5; c++) begin
            wr(intc_pkg::ADDR_TRIG_LO, c);
            wr(intc_pkg::ADDR_CLEAR_HI, 32'h8);
            settle();
            rd(intc_pkg::ADDR_STATUS_HI, d); check(d[3], trig_exp[c][2]);
            @(posedge clk_sys) exp_in <= 16'h1;
            settle();
            rd(intc_pkg::ADDR_STATUS_HI, d); check(d[3], trig_exp[c][1]);
            wr(intc_pkg::ADDR_CLEAR_HI, 32'h8);
            @(posedge clk_sys) exp_in <= 16'h0;
            settle();
            rd(intc_pkg::ADDR_STATUS_HI, d); check(d[3], trig_exp[c][0]);
        end
        $display("test triggers done");

        // rising edge stays pending after the pin falls
        wr(intc_pkg::ADDR_TRIG_LO, 32'h2);
        wr(intc_pkg::ADDR_SLOT_BASE + 8'h08, 32'h23);
        wr(intc_pkg::ADDR_CLEAR_HI, 32'h8);
        @(posedge clk_sys) exp_in <= 16'h1;
        wait_req(1'b0, 1'b1);
        @(posedge clk_sys) exp_in <= 16'h0;
        settle();
        check({31'h0, normal_interrupt_request}, 32'h1);
        wr(intc_pkg::ADDR_CLEAR_HI, 32'h8);
        wait_req(1'b0, 1'b0);
        $display("test pending done");

        // output mode drives the pin and never interrupts
        wr(intc_pkg::ADDR_PIN_DIR, 32'h0001_0001);
        wr(intc_pkg::ADDR_PIN_DATA, 32'h0001_0001);
        settle();
        check({exp_oe, exp_out}, 32'h0001_0001);
        check({26'h0, sec_oe, sec_out}, 32'h0000_0009);
        @(posedge clk_sys) exp_in <= 16'h1;
        settle();
        rd(intc_pkg::ADDR_STATUS_HI, d); check(d & 32'h8, 32'h0);
        // plain input: level readable, no interrupt
        wr(intc_pkg::ADDR_PIN_DIR, 32'h0);
        wr(intc_pkg::ADDR_PIN_INT, 32'h0);
        @(posedge clk_sys) exp_in <= 16'h0;
        settle();
        @(posedge clk_sys) exp_in <= 16'h1;
        settle();
        rd(intc_pkg::ADDR_PIN_LEVEL, d); check(d & 32'h1, 32'h1);
        rd(intc_pkg::ADDR_STATUS_HI, d); check(d & 32'h8, 32'h0);
        // secondary pin 16 is source 51, high level by default
        wr(intc_pkg::ADDR_PIN_INT, 32'h0001_0000);
        @(posedge clk_sys) sec_in <= 3'h1;
        settle();
        rd(intc_pkg::ADDR_STATUS_HI, d); check(d & 32'h8_0000, 32'h8_0000);
        $display("test pins done");
        final_report();
    end
endmodule // soc_interrupt_controller_tb
`default_nettype wire
